// ### hw/cps_pkg.sv
// Package: opcodes, status byte layout and timing for the status unit
package cps_pkg;

  // Full-byte opcodes
  localparam logic [7:0] OP_HALT      = 8'h40;
  localparam logic [7:0] OP_NOP       = 8'hc0;
  localparam logic [7:0] OP_LOAD_SU   = 8'h92;
  localparam logic [7:0] OP_LOAD_SL   = 8'h93;
  localparam logic [7:0] OP_STORE_SU  = 8'h12;
  localparam logic [7:0] OP_STORE_SL  = 8'h13;
  localparam logic [7:0] OP_CLEAR_SU  = 8'h74;
  localparam logic [7:0] OP_CLEAR_SL  = 8'h75;
  localparam logic [7:0] OP_PRESET_SU = 8'h76;
  localparam logic [7:0] OP_PRESET_SL = 8'h77;
  localparam logic [7:0] OP_TEST_SU   = 8'hb4;
  localparam logic [7:0] OP_TEST_SL   = 8'hb5;
  localparam logic [7:0] OP_BXA       = 8'h9f;
  localparam logic [7:0] OP_BSXA      = 8'hbf;

  // Six-bit opcodes (register field in bits 1:0)
  localparam logic [5:0] OP6_TMI   = 6'h3d;
  localparam logic [5:0] OP6_WRITE_CONTROL_PORT  = 6'h2c;
  localparam logic [5:0] OP6_READ_CONTROL_PORT  = 6'h0c;
  localparam logic [5:0] OP6_WRITE_EXTENDED_PORT  = 6'h35;
  localparam logic [5:0] OP6_READ_EXTENDED_PORT  = 6'h15;
  localparam logic [5:0] OP6_COMZ  = 6'h38;
  localparam logic [5:0] OP6_COMI  = 6'h39;
  localparam logic [5:0] OP6_DAR   = 6'h25;
  localparam logic [5:0] OP6_LODZ  = 6'h00;
  localparam logic [5:0] OP6_LODI  = 6'h01;

  // Condition code encodings
  localparam logic [1:0] CC_POS = 2'h1;
  localparam logic [1:0] CC_ZERO = 2'h0;
  localparam logic [1:0] CC_NEG = 2'h2;

  // Upper status byte fields
  localparam int SU_SENSE = 7;
  localparam int SU_FLAG  = 6;
  localparam int SU_II    = 5;
  localparam logic [7:0] SU_WRITABLE = 8'h67;  // Flag, inhibit, stack ptr
  // Lower status byte fields
  localparam int SL_CC_HI = 7;
  localparam int SL_CC_LO = 6;
  localparam int SL_IDC   = 5;
  localparam int SL_RS    = 4;
  localparam int SL_WC    = 3;
  localparam int SL_OVF   = 2;
  localparam int SL_COM   = 1;
  localparam int SL_CARRY = 0;

  localparam logic [7:0] SU_RESET = 8'h00;
  localparam logic [7:0] SL_RESET = 8'h00;
  localparam logic [1:0] INDEX_REG = 2'h3;  // Index for indexed branches

  // Instruction lengths in cycles
  localparam logic [1:0] CYC_TWO   = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_FETCH = 2'b00,
    ST_IMM   = 2'b01,
    ST_EXEC  = 2'b10,
    ST_WAIT  = 2'b11
  } cps_state_type;

endpackage : cps_pkg

// ### hw/cps_cc_gen.sv
// Condition code generator for results, compares and masked tests
`timescale 1ns/1ps
`default_nettype none
module cps_cc_gen
  import cps_pkg::*;
(
  // Operands
  input  wire logic [7:0] value_a,
  input  wire logic [7:0] value_b,
  input  wire logic       compare,
  input  wire logic       logical,
  input  wire logic       mask_test,
  // Result
  output logic [1:0]      cc
);

  logic a_gt_b;
  logic all_ones;

  // Logical compare is unsigned, arithmetic compare is two's complement
  always_comb begin
    if (logical) begin
      a_gt_b = value_a > value_b;
    end else begin
      a_gt_b = $signed(value_a) > $signed(value_b);
    end
    all_ones = (value_a & value_b) == value_b;
  end

  // Select the encoding for the operation kind
  always_comb begin
    if (mask_test) begin
      cc = all_ones ? CC_ZERO : CC_NEG;
    end else if (compare) begin
      if (value_a == value_b) begin
        cc = CC_ZERO;
      end else begin
        cc = a_gt_b ? CC_POS : CC_NEG;
      end
    end else if (value_a == 8'h00) begin
      cc = CC_ZERO;
    end else begin
      cc = value_a[7] ? CC_NEG : CC_POS;
    end
  end

endmodule : cps_cc_gen
`default_nettype wire

// ### hw/cps_status_unit.sv
// Program status decode and execution unit for an 8-bit processor
// Overview of operation
// - Opcode 40 is halt, two cycles, then the processor waits.
// - Test under mask immediate, two bytes, three cycles, updates cond code.
// - Masked test gives 00 if all selected bits set, else 10.
// - Load upper/lower status from register, one byte, two cycles.
// - Store upper/lower status into register, cond code from sign.
// - Clear status bits selected by ones in immediate mask.
// - Preset status bits selected by ones in immediate mask.
// - Test status bits selected by immediate mask into cond code.
// - Data and logic results: 01 positive, 00 zero, 10 negative.
// - Decimal adjust leaves the condition code undefined.
// - Indexed absolute branches always use register three.
// - Upper byte: sense, flag, inhibit, two unused, three stack bits.
// - Lower byte: cc high, cc low, idc, bank, wc, ovf, com, carry.
`timescale 1ns/1ps
`default_nettype none
module cps_status_unit
  import cps_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rstn,
  // Instruction stream
  input  wire logic       instr_valid,
  input  wire logic [7:0] instr_byte,
  output logic            instr_ready,
  // Register file side
  input  wire logic [7:0] reg_rdata,
  input  wire logic [7:0] reg_zero,
  output logic [1:0]      reg_sel,
  output logic            reg_we,
  output logic [7:0]      reg_wdata,
  // External signals
  input  wire logic       sense_in,
  input  wire logic [7:0] io_rdata,
  output logic            io_wr,
  output logic            io_rd,
  output logic            io_ext,
  output logic [7:0]      io_addr,
  output logic [7:0]      io_wdata,
  output logic            halted,
  // Status bytes
  output logic [7:0]      status_upper_byte,
  output logic [7:0]      status_lower_byte,
  output logic            instr_done
);

  logic rst_meta;
  logic rst_sync;
  cps_state_type state;
  cps_state_type next_state;
  logic [7:0] opcode;
  logic [7:0] next_opcode;
  logic [7:0] imm;
  logic [7:0] next_imm;
  logic [4:0] su_store;
  logic [4:0] next_su_store;
  logic [7:0] sl_store;
  logic [7:0] next_sl_store;
  logic [7:0] su_view;
  logic [7:0] cc_a;
  logic [7:0] cc_b;
  logic       cc_cmp;
  logic       cc_mask;
  logic [1:0] cc_out;
  logic       next_reg_we;
  logic [7:0] next_reg_wdata;
  logic [1:0] next_reg_sel;
  logic       next_io_wr;
  logic       next_io_rd;
  logic       next_io_ext;
  logic [7:0] next_io_addr;
  logic [7:0] next_io_wdata;
  logic       next_done;
  logic       two_byte;

  // Reset release through two flops; assertion is still immediate
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // Sense bit follows its pin; unused bits read as zero
  assign su_view = {sense_in, su_store[4:3], 2'b00, su_store[2:0]};
  assign status_upper_byte = su_view;
  assign status_lower_byte = sl_store;
  assign instr_ready = (state == ST_FETCH) || (state == ST_IMM);
  assign halted = (state == ST_WAIT);

  // Immediate follows any of these six-bit or full-byte opcodes
  always_comb begin
    two_byte = (instr_byte[7:2] == OP6_TMI)
            || (instr_byte[7:2] == OP6_WRITE_EXTENDED_PORT)
            || (instr_byte[7:2] == OP6_READ_EXTENDED_PORT)
            || (instr_byte[7:2] == OP6_COMI)
            || (instr_byte[7:2] == OP6_LODI)
            || (instr_byte == OP_CLEAR_SU) || (instr_byte == OP_CLEAR_SL)
            || (instr_byte == OP_PRESET_SU) || (instr_byte == OP_PRESET_SL)
            || (instr_byte == OP_TEST_SU) || (instr_byte == OP_TEST_SL);
  end

  // Condition code source selection
  always_comb begin
    cc_a = reg_rdata;
    cc_b = imm;
    cc_cmp = 1'b0;
    cc_mask = 1'b0;
    if (opcode[7:2] == OP6_TMI) begin
      cc_mask = 1'b1;
    end else if (opcode == OP_TEST_SU) begin
      cc_a = su_view;
      cc_mask = 1'b1;
    end else if (opcode == OP_TEST_SL) begin
      cc_a = sl_store;
      cc_mask = 1'b1;
    end else if (opcode[7:2] == OP6_COMZ) begin
      cc_a = reg_zero;
      cc_b = reg_rdata;
      cc_cmp = 1'b1;
    end else if (opcode[7:2] == OP6_COMI) begin
      cc_cmp = 1'b1;
    end else if (opcode == OP_STORE_SU) begin
      cc_a = su_view;
    end else if (opcode == OP_STORE_SL) begin
      cc_a = sl_store;
    end else if ((opcode[7:2] == OP6_READ_CONTROL_PORT) || (opcode[7:2] == OP6_READ_EXTENDED_PORT)) begin
      cc_a = io_rdata;
    end else if (opcode[7:2] == OP6_LODI) begin
      cc_a = imm;
    end
  end

  cps_cc_gen u_cc (
    .value_a   (cc_a),
    .value_b   (cc_b),
    .compare   (cc_cmp),
    .logical   (sl_store[SL_COM]),
    .mask_test (cc_mask),
    .cc        (cc_out)
  );

  // Sequencer and execution next-state logic
  always_comb begin
    next_state = state;
    next_opcode = opcode;
    next_imm = imm;
    next_su_store = su_store;
    next_sl_store = sl_store;
    next_reg_we = 1'b0;
    next_reg_wdata = reg_wdata;
    next_reg_sel = reg_sel;
    next_io_wr = 1'b0;
    next_io_rd = 1'b0;
    next_io_ext = io_ext;
    next_io_addr = io_addr;
    next_io_wdata = io_wdata;
    next_done = 1'b0;
    case (state)
      ST_FETCH: begin
        if (instr_valid) begin
          next_opcode = instr_byte;
          next_reg_sel = instr_byte[1:0];
          if ((instr_byte == OP_BXA) || (instr_byte == OP_BSXA)) begin
            next_reg_sel = INDEX_REG;
          end
          next_state = two_byte ? ST_IMM : ST_EXEC;
        end
      end
      ST_IMM: begin
        if (instr_valid) begin
          next_imm = instr_byte;
          next_state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        // Status changes, write-backs and I/O all land in the last cycle
        next_state = ST_FETCH;
        next_done = 1'b1;
        case (opcode)
          OP_HALT: next_state = ST_WAIT;
          OP_NOP: next_state = ST_FETCH;
          OP_LOAD_SU: begin
            next_su_store = {reg_rdata[SU_FLAG], reg_rdata[SU_II],
                             reg_rdata[2:0]};
          end
          OP_LOAD_SL: next_sl_store = reg_rdata;
          OP_STORE_SU, OP_STORE_SL: begin
            next_reg_we = 1'b1;
            next_reg_wdata = cc_a;
            next_sl_store[SL_CC_HI:SL_CC_LO] = cc_out;
          end
          OP_CLEAR_SU: begin
            next_su_store = su_store & ~{imm[SU_FLAG], imm[SU_II],
                                         imm[2:0]};
          end
          OP_CLEAR_SL: next_sl_store = sl_store & ~imm;
          OP_PRESET_SU: begin
            next_su_store = su_store | {imm[SU_FLAG], imm[SU_II],
                                        imm[2:0]};
          end
          OP_PRESET_SL: next_sl_store = sl_store | imm;
          OP_TEST_SU, OP_TEST_SL: begin
            next_sl_store[SL_CC_HI:SL_CC_LO] = cc_out;
          end
          default: begin
            if ((opcode[7:2] == OP6_WRITE_CONTROL_PORT) || (opcode[7:2] == OP6_WRITE_EXTENDED_PORT)) begin
              next_io_wr = 1'b1;
              next_io_ext = (opcode[7:2] == OP6_WRITE_EXTENDED_PORT);
              next_io_addr = imm;
              next_io_wdata = reg_rdata;
            end else if ((opcode[7:2] == OP6_READ_CONTROL_PORT)
                      || (opcode[7:2] == OP6_READ_EXTENDED_PORT)) begin
              next_io_rd = 1'b1;
              next_io_ext = (opcode[7:2] == OP6_READ_EXTENDED_PORT);
              next_io_addr = imm;
              next_reg_we = 1'b1;
              next_reg_wdata = io_rdata;
              next_sl_store[SL_CC_HI:SL_CC_LO] = cc_out;
            end else if (opcode[7:2] == OP6_DAR) begin
              // Code left as is; software must not trust it
              next_sl_store = sl_store;
            end else if ((opcode[7:2] == OP6_TMI)
                      || (opcode[7:2] == OP6_COMZ)
                      || (opcode[7:2] == OP6_COMI)
                      || (opcode[7:2] == OP6_LODI)) begin
              next_sl_store[SL_CC_HI:SL_CC_LO] = cc_out;
              if (opcode[7:2] == OP6_LODI) begin
                next_reg_we = 1'b1;
                next_reg_wdata = imm;
              end
            end
          end
        endcase
      end
      ST_WAIT: next_state = ST_WAIT;  // Only reset leaves halt
      default: next_state = ST_FETCH;
    endcase
  end

  // State registers
  always_ff @(posedge mclk or negedge rst_sync) begin
    if (!rst_sync) begin
      state <= ST_FETCH;
      opcode <= OP_NOP;
      imm <= 8'h00;
      su_store <= SU_RESET[4:0];
      sl_store <= SL_RESET;
      reg_we <= 1'b0;
      reg_wdata <= 8'h00;
      reg_sel <= 2'h0;
      io_wr <= 1'b0;
      io_rd <= 1'b0;
      io_ext <= 1'b0;
      io_addr <= 8'h00;
      io_wdata <= 8'h00;
      instr_done <= 1'b0;
    end else begin
      state <= next_state;
      opcode <= next_opcode;
      imm <= next_imm;
      su_store <= next_su_store;
      sl_store <= next_sl_store;
      reg_we <= next_reg_we;
      reg_wdata <= next_reg_wdata;
      reg_sel <= next_reg_sel;
      io_wr <= next_io_wr;
      io_rd <= next_io_rd;
      io_ext <= next_io_ext;
      io_addr <= next_io_addr;
      io_wdata <= next_io_wdata;
      instr_done <= next_done;
    end
  end

endmodule : cps_status_unit
`default_nettype wire

// ### tb/cps_status_properties.sv
// Checker: timing, layout and masked edits of the status unit
`timescale 1ns/1ps
`default_nettype none
module cps_status_checker
  import cps_pkg::*;
(
  // Clock, reset and instruction stream
  input wire logic       mclk,
  input wire logic       rstn,
  input wire logic       instr_valid,
  input wire logic [7:0] instr_byte,
  input wire logic       instr_ready,
  input wire logic       instr_done,
  // Register and io side
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_we,
  input wire logic [7:0] reg_wdata,
  input wire logic       io_wr,
  // Status
  input wire logic       sense_in,
  input wire logic       halted,
  input wire logic [7:0] status_upper_byte,
  input wire logic [7:0] status_lower_byte
);
  logic       take, op_take, imm_take, two_byte, imm_next, next_imm_next;
  logic [7:0] last_op, next_last_op;
  logic [7:0] sl;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  // Sequencer is hidden, so the opcode/immediate phase is rebuilt here
  assign sl       = status_lower_byte;
  assign take     = instr_valid && instr_ready;
  assign op_take  = take && !imm_next;
  assign imm_take = take && imm_next;
  assign two_byte = instr_byte[7:2] inside {6'h1d, 6'h2d, OP6_TMI,
                    OP6_WRITE_EXTENDED_PORT, OP6_READ_EXTENDED_PORT, OP6_COMI, OP6_LODI};
  always_comb begin
    next_imm_next = imm_next;
    next_last_op  = last_op;
    if (op_take) begin
      next_imm_next = two_byte;
      next_last_op  = instr_byte;
    end else if (imm_take) begin
      next_imm_next = 1'b0;
    end
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      imm_next <= 1'b0;
      last_op  <= 8'h00;
    end else begin
      imm_next <= next_imm_next;
      last_op  <= next_last_op;
    end
  end

  // Execute cycle with fetch stalled, then the completion pulse
  sequence exec_done;
    !instr_ready ##1 instr_done;
  endsequence
  sequence short_op;
    op_take && !two_byte && instr_byte != OP_HALT;
  endsequence

  one_byte_a: assert property (short_op |=> exec_done)
    else $error("one-byte op not done in two cycles");
  two_byte_a: assert property (imm_take |=> exec_done)
    else $error("two-byte op not done in three cycles");
  halt_enter_a: assert property (
    op_take && instr_byte == OP_HALT |=> !instr_ready ##1 halted [*3])
    else $error("halt did not enter wait");
  halt_hold_a: assert property (halted |=> halted && !instr_ready)
    else $error("wait state left or byte taken");
  upper_fields_a: assert property (
    status_upper_byte[7] == sense_in && status_upper_byte[4:3] == 2'h0)
    else $error("upper status layout wrong");
  load_lower_a: assert property (
    op_take && instr_byte == OP_LOAD_SL |=> ##1 sl == $past(reg_rdata))
    else $error("lower load wrong");
  store_lower_a: assert property (
    op_take && instr_byte == OP_STORE_SL |=> ##1 reg_we &&
    reg_wdata == $past(sl) && sl[7:6] == (reg_wdata[7] ? CC_NEG :
    (reg_wdata == 8'h00 ? CC_ZERO : CC_POS)))
    else $error("lower store wrong");
  clear_lower_a: assert property (
    imm_take && last_op == OP_CLEAR_SL |=> ##1
    sl == ($past(sl, 2) & ~$past(instr_byte, 2)))
    else $error("masked clear wrong");
  test_lower_a: assert property (
    imm_take && last_op == OP_TEST_SL |=> ##1 sl[7:6] ==
    ((($past(sl, 2) & $past(instr_byte, 2)) == $past(instr_byte, 2)) ?
    CC_ZERO : CC_NEG))
    else $error("masked test cc wrong");
  io_pulse_a: assert property (io_wr |-> instr_done ##1 !io_wr)
    else $error("io write pulse wrong");
endmodule : cps_status_checker

bind cps_status_unit cps_status_checker chk (.*);
`default_nettype wire

// ### tb/testbench.sv
// Testbench: directed instruction sequences for the status unit
`timescale 1ns/1ps
`default_nettype none
module testbench
  import cps_pkg::*;
;
  logic       mclk, rstn, instr_valid, sense_in, instr_ready, reg_we;
  logic       io_wr, io_rd, io_ext, halted, instr_done;
  logic [1:0] reg_sel;
  logic [7:0] instr_byte, io_rdata, reg_wdata, io_addr, io_wdata, su, sl;
  logic [7:0] regs [4];
  int         n_errors, cmp_count, t;

  cps_status_unit dut (
    .mclk, .rstn, .instr_valid, .instr_byte, .instr_ready,
    .reg_rdata(regs[reg_sel]), .reg_zero(regs[0]), .reg_sel, .reg_we,
    .reg_wdata, .sense_in, .io_rdata, .io_wr, .io_rd, .io_ext, .io_addr,
    .io_wdata, .halted, .status_upper_byte(su), .status_lower_byte(sl),
    .instr_done
  );

  // Free-running clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic summarize;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One bounded wait step; a hang ends the run as a failure
  task automatic limit;
    t++;
    if (t > 20) begin
      n_errors++;
      summarize();
    end
    @(posedge mclk);
    #1;
  endtask : limit

  // Offer a byte and hold it until the edge that takes it
  task automatic put(input logic [7:0] b);
    instr_valid <= 1'b1;
    instr_byte  <= b;
    t = 0;
    #1;
    while (instr_ready !== 1'b1) limit();
    @(posedge mclk);
  endtask : put

  task automatic go(input logic [7:0] op, input logic [7:0] imm,
                    input bit two, input logic [7:0] e_sl);
    @(posedge mclk);
    put(op);
    if (two) put(imm);
    instr_valid <= 1'b0;
    t = 0;
    #1;
    while (instr_done !== 1'b1) limit();
    chk("lower status", e_sl, sl);
  endtask : go

  // Expected bytes follow from the register contents set below
  initial begin
    rstn        = 1'b0;
    instr_valid = 1'b0;
    instr_byte  = 8'h00;
    sense_in    = 1'b1;
    io_rdata    = 8'h81;
    regs        = '{8'h10, 8'h20, 8'hff, 8'h9a};
    n_errors    = 0;
    cmp_count   = 0;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk("upper reset", 8'h80, su);
    go(OP_LOAD_SL, 8'h00, 0, 8'h9a);
    go(OP_LOAD_SU, 8'h00, 0, 8'h9a);
    chk("upper load", 8'he7, su);
    @(posedge mclk);
    sense_in <= 1'b0;
    #1;
    chk("upper sense", 8'h67, su);
    go(OP_STORE_SL, 8'h00, 0, 8'h9a);
    chk("store data", 8'h9a, reg_wdata);
    go(OP_STORE_SU, 8'h00, 0, 8'h5a);
    chk("store data", 8'h67, reg_wdata);
    go(OP_CLEAR_SL, 8'h0a, 1, 8'h50);
    go(OP_PRESET_SL, 8'h05, 1, 8'h55);
    go(OP_TEST_SL, 8'h05, 1, 8'h15);
    go(OP_TEST_SL, 8'h0c, 1, 8'h95);
    go(OP_TEST_SU, 8'h60, 1, 8'h15);
    go(OP_CLEAR_SU, 8'h45, 1, 8'h15);
    chk("upper clear", 8'h22, su);
    go(OP_PRESET_SU, 8'h19, 1, 8'h15);
    chk("upper preset", 8'h23, su);
    go({OP6_TMI, 2'h1}, 8'h21, 1, 8'h95);
    go({OP6_TMI, 2'h1}, 8'h20, 1, 8'h15);
    go({OP6_LODI, 2'h1}, 8'h80, 1, 8'h95);
    go({OP6_LODI, 2'h1}, 8'h00, 1, 8'h15);
    go({OP6_LODI, 2'h1}, 8'h7f, 1, 8'h55);
    go({OP6_COMZ, 2'h1}, 8'h00, 0, 8'h95);
    go({OP6_COMI, 2'h1}, 8'h10, 1, 8'h55);
    go({OP6_COMI, 2'h1}, 8'h20, 1, 8'h15);
    go({OP6_COMI, 2'h1}, 8'h30, 1, 8'h95);
    go({OP6_WRITE_CONTROL_PORT, 2'h2}, 8'h00, 0, 8'h95);
    chk("io write", 8'h01, io_wr);
    chk("io ctrl", 8'h00, io_ext);
    chk("io data", 8'hff, io_wdata);
    go({OP6_WRITE_EXTENDED_PORT, 2'h1}, 8'h3c, 1, 8'h95);
    chk("io ext", 8'h01, io_ext);
    chk("io addr", 8'h3c, io_addr);
    go({OP6_READ_CONTROL_PORT, 2'h1}, 8'h00, 0, 8'h95);
    chk("io read", 8'h01, io_rd);
    @(posedge mclk);
    io_rdata <= 8'h00;
    go({OP6_READ_EXTENDED_PORT, 2'h1}, 8'h44, 1, 8'h15);
    chk("read data", 8'h00, reg_wdata);
    // Logical compare mode: 0x20 below 0x90 unsigned, above it signed
    go(OP_PRESET_SL, 8'h02, 1, 8'h17);
    go({OP6_COMI, 2'h1}, 8'h90, 1, 8'h97);
    go({OP6_DAR, 2'h1}, 8'h00, 0, 8'h97);
    go(OP_BXA, 8'h00, 0, 8'h97);
    chk("index reg", 8'h03, reg_sel);
    go(OP_NOP, 8'h00, 0, 8'h97);
    chk("nop upper", 8'h23, su);
    chk("nop write", 8'h00, reg_we);
    // Halt, then offer a load that must be refused
    @(posedge mclk);
    put(OP_HALT);
    instr_byte <= OP_LOAD_SU;
    repeat (4) @(posedge mclk);
    #1;
    chk("halted", 8'h01, halted);
    chk("halt upper", 8'h23, su);
    // Only a reset leaves the wait state; drop the offer in the same cycle
    @(posedge mclk);
    rstn        <= 1'b0;
    instr_valid <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk("reset halt", 8'h00, halted);
    chk("reset lower", 8'h00, sl);
    go(OP_LOAD_SL, 8'h00, 0, 8'h9a);
    summarize();
  end
endmodule : testbench
`default_nettype wire
